// ===== design/dgcr_regs.svh
// Purpose: Offsets, field positions, reset values and timing counts of the
//          deserializer general control registers.
// Assumes: Registers are reached by byte offset over the documented control port.
// Notes:   Definitions only.
// Summary of operation
// - Address field bits 7:1 hold register address, loaded from strap on reset
// - Bit 0 selects strap or register address
// - Reset bit 1 resets all, self-clears
// - Full soft reset reloads strapped register values
// - Reset bit 0 resets logic, keeps registers
// - Config bit 6 enables output override
// - Config bit 7 gives overridden output enable
// - Config bit 4 gives overridden sleep state
// - Config bit 5 puts oscillator on pixel clock while link is unlocked
`ifndef DGCR_REGS_SVH
`define DGCR_REGS_SVH

`define DGCR_OFS_ADDR       8'h00
`define DGCR_OFS_RESET      8'h01
`define DGCR_OFS_CFG0       8'h02

`define DGCR_ADDR_SRC_BIT   0
`define DGCR_ADDR_ID_MSB    7
`define DGCR_ADDR_ID_LSB    1

`define DGCR_RST_LOGIC_BIT  0
`define DGCR_RST_FULL_BIT   1
`define DGCR_RST_FIXED_BIT  2

`define DGCR_CFG_SLEEP_BIT  4
`define DGCR_CFG_ACLK_BIT   5
`define DGCR_CFG_OVR_BIT    6
`define DGCR_CFG_OE_BIT     7

`define DGCR_ADDR_SRC_RST   1'h0
`define DGCR_CFG_OE_RST     1'h1
`define DGCR_CFG_OVR_RST    1'h0
`define DGCR_CFG_ACLK_RST   1'h0
`define DGCR_CFG_SLEEP_RST  1'h0
`define DGCR_RST_RSV_HI     5'h00
`define DGCR_RST_FIXED_VAL  1'h1
`define DGCR_CFG_RSV_LO     4'h0
`define DGCR_UNMAPPED_DATA  8'h00

`define DGCR_SRST_CYCLES    4

`endif

// ===== design/dgcr_pkg.sv
// Purpose: Types shared by the general control register bank.
// Assumes: Constants live in dgcr_regs.svh.
// Notes:   State of each module is one packed struct.
package dgcr_pkg;

	// Register bank state
	typedef struct packed {
		logic       strap_loaded;
		logic [6:0] strap_latch;
		logic [6:0] dev_id;
		logic       src_sel;
		logic       cfg_oe;
		logic       cfg_ovr;
		logic       cfg_aclk;
		logic       cfg_sleep;
		logic [7:0] rdata;
		logic       rvalid;
		logic [6:0] slave_addr;
		logic       out_en;
		logic       out_sleep;
		logic       pclk_swap;
		logic       core_reset_n;
	} dgcr_bank_t;

	// Soft reset pulse state
	typedef struct packed {
		logic [7:0] cnt;
	} dgcr_pulse_t;

endpackage

// ===== design/dgcr_srst_if.sv
// Purpose: Carries one soft reset request and its busy answer.
// Assumes: One clock domain.
// Notes:   Trigger is a one-cycle pulse.
`timescale 1ns/10ps
`default_nettype none
interface dgcr_srst_if;
	logic trig;
	logic busy;

	modport req
	(
		output trig,
		input  busy
	);
	modport gen
	(
		input  trig,
		output busy
	);
endinterface // dgcr_srst_if
`default_nettype wire

// ===== design/dgcr_reset_pulse.sv
// Purpose: Stretches a soft reset trigger into a fixed-length busy pulse.
// Assumes: Trigger is a one-cycle pulse; clk at 100 MHz.
// Notes:   A trigger during a running pulse is ignored.
`timescale 1ns/10ps
`default_nettype none
`include "dgcr_regs.svh"
module dgcr_reset_pulse
	import dgcr_pkg::*;
#(
	parameter int LEN = `DGCR_SRST_CYCLES
)
(
	input  wire logic   clk,
	input  wire logic   nrst,
	dgcr_srst_if.gen    srst
);
	dgcr_pulse_t st;
	dgcr_pulse_t next_st;

	// Load the length on a trigger, then count down to idle
	always_comb
	begin
		next_st = st;
		if (st.cnt != 8'h00)
			next_st.cnt = st.cnt - 8'h01;
		else if (srst.trig)
			next_st.cnt = 8'(LEN);
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			st <= '0;
		else
			st <= next_st;
	end

	// Counter is a flop, so busy is glitch free
	assign srst.busy = (st.cnt != 8'h00);

	pulse_len_a: assert property (@(posedge clk) disable iff (!nrst)
		(srst.trig && !srst.busy) |=> srst.busy [*4] ##1 !srst.busy)
		else $error("soft reset pulse length wrong");
endmodule // dgcr_reset_pulse
`default_nettype wire

// ===== design/dgcr_ctrl.sv
// Purpose: General control registers: slave address, soft resets, output control.
// Assumes: reg_wr and reg_rd are one-cycle strobes decoded by the control bus slave.
// Notes:   Read data appear one cycle after reg_rd, marked by reg_rvalid.
`timescale 1ns/10ps
`default_nettype none
`include "dgcr_regs.svh"
module dgcr_ctrl
	import dgcr_pkg::*;
#(
	parameter int SRST_CYCLES = `DGCR_SRST_CYCLES
)
(
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic [6:0] address_strap_pin,
	input  wire logic       link_lock,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output logic [7:0]      reg_rdata,
	output logic            reg_rvalid,
	output logic [6:0]      slave_addr,
	output logic            output_enable,
	output logic            output_sleep_state_select,
	output logic            internal_oscillator_on_pclk,
	output logic            core_reset_n
);
	dgcr_bank_t st;
	dgcr_bank_t next_st;

	dgcr_srst_if full_if ();
	dgcr_srst_if logic_if ();

	logic wr_addr;
	logic wr_rst;
	logic wr_cfg;
	logic full_busy;
	logic logic_busy;

	// Register decode
	assign wr_addr = reg_wr && (reg_addr == `DGCR_OFS_ADDR);
	assign wr_rst  = reg_wr && (reg_addr == `DGCR_OFS_RESET);
	assign wr_cfg  = reg_wr && (reg_addr == `DGCR_OFS_CFG0);

	// Self-clearing reset bits only raise a trigger; nothing is stored
	assign full_if.trig  = wr_rst && reg_wdata[`DGCR_RST_FULL_BIT];
	assign logic_if.trig = wr_rst && reg_wdata[`DGCR_RST_LOGIC_BIT];
	assign full_busy     = full_if.busy;
	assign logic_busy    = logic_if.busy;

	// Two identical pulse stretchers, one for each soft reset
	dgcr_reset_pulse #(.LEN(SRST_CYCLES)) u_full_pulse
	(
		.clk  (clk),
		.nrst (nrst),
		.srst (full_if.gen)
	);

	dgcr_reset_pulse #(.LEN(SRST_CYCLES)) u_logic_pulse
	(
		.clk  (clk),
		.nrst (nrst),
		.srst (logic_if.gen)
	);

	// Next state of the whole bank
	always_comb
	begin
		next_st = st;
		next_st.rvalid = 1'b0;

		// Strap is caught after reset release, never under the async reset
		if (!st.strap_loaded || full_busy)
		begin
			next_st.strap_loaded = 1'b1;
			next_st.strap_latch  = address_strap_pin;
			next_st.dev_id       = address_strap_pin;
		end

		if (full_busy)
		begin
			// Whole register set back to defaults; writes lose during the pulse
			next_st.src_sel = `DGCR_ADDR_SRC_RST;
			next_st.cfg_oe  = `DGCR_CFG_OE_RST;
			next_st.cfg_ovr = `DGCR_CFG_OVR_RST;
			next_st.cfg_aclk  = `DGCR_CFG_ACLK_RST;
			next_st.cfg_sleep = `DGCR_CFG_SLEEP_RST;
		end
		else
		begin
			// Logic reset leaves registers alone, so writes still land
			if (wr_addr)
			begin
				next_st.dev_id  = reg_wdata[`DGCR_ADDR_ID_MSB:`DGCR_ADDR_ID_LSB];
				next_st.src_sel = reg_wdata[`DGCR_ADDR_SRC_BIT];
			end
			// Reserved low bits are dropped, they always read their default
			if (wr_cfg)
			begin
				next_st.cfg_oe  = reg_wdata[`DGCR_CFG_OE_BIT];
				next_st.cfg_ovr = reg_wdata[`DGCR_CFG_OVR_BIT];
				next_st.cfg_aclk  = reg_wdata[`DGCR_CFG_ACLK_BIT];
				next_st.cfg_sleep = reg_wdata[`DGCR_CFG_SLEEP_BIT];
			end
		end

		// Read mux; unmapped offsets answer with zero
		if (reg_rd)
		begin
			next_st.rvalid = 1'b1;
			case (reg_addr)
				`DGCR_OFS_ADDR:
					next_st.rdata = {st.dev_id, st.src_sel};
				`DGCR_OFS_RESET:
					next_st.rdata = {`DGCR_RST_RSV_HI, `DGCR_RST_FIXED_VAL,
						full_busy, logic_busy};
				`DGCR_OFS_CFG0:
					next_st.rdata = {st.cfg_oe, st.cfg_ovr, st.cfg_aclk, st.cfg_sleep,
						`DGCR_CFG_RSV_LO};
				default:
					next_st.rdata = `DGCR_UNMAPPED_DATA;
			endcase
		end

		// Active bus address follows the source select
		next_st.slave_addr = st.src_sel ? st.dev_id : st.strap_latch;

		// Without override both effective controls sit at 1
		next_st.out_en  = st.cfg_ovr ? st.cfg_oe  : 1'b1;
		next_st.out_sleep = st.cfg_ovr ? st.cfg_sleep : 1'b1;

		// Oscillator clock replaces the recovered clock only while unlocked
		next_st.pclk_swap = st.cfg_aclk && !link_lock;

		// Either soft reset holds the core logic in reset
		next_st.core_reset_n = !(full_busy || logic_busy);
	end

	// Register the bank; reset values are constants only
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			st              <= '0;
			st.cfg_oe       <= `DGCR_CFG_OE_RST;
			st.out_en       <= 1'b1;
			st.out_sleep    <= 1'b1;
			st.core_reset_n <= 1'b0;
		end
		else
			st <= next_st;
	end

	// Outputs straight from flops
	assign reg_rdata                 = st.rdata;
	assign reg_rvalid                = st.rvalid;
	assign slave_addr                = st.slave_addr;
	assign output_enable             = st.out_en;
	assign output_sleep_state_select = st.out_sleep;
	assign internal_oscillator_on_pclk = st.pclk_swap;
	assign core_reset_n              = st.core_reset_n;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	strap_load_a: assert property (full_busy |=> ##1
		(slave_addr == $past(address_strap_pin, 2)) || st.src_sel)
		else $error("strap address not reloaded");

	addr_source_a: assert property ((wr_addr && !full_busy) |=> ##1
		(slave_addr == ($past(reg_wdata[0], 2) ? $past(reg_wdata[7:1], 2)
		: st.strap_latch)))
		else $error("slave address source wrong");

	full_reset_a: assert property ((full_if.trig && !full_busy) |=>
		##1 !core_reset_n ##[1:16] core_reset_n)
		else $error("full soft reset not applied or not released");

	full_defaults_a: assert property (full_busy |=>
		st.cfg_oe && !st.cfg_ovr && !st.cfg_aclk && !st.cfg_sleep && !st.src_sel)
		else $error("register not restored by full soft reset");

	logic_keep_a: assert property ((logic_busy && !full_busy && !reg_wr) |=>
		$stable({st.dev_id, st.src_sel, st.cfg_oe, st.cfg_ovr, st.cfg_aclk, st.cfg_sleep}))
		else $error("logic soft reset disturbed registers");

	override_oe_a: assert property ((st.cfg_ovr && $stable(st.cfg_oe)) |=>
		output_enable == $past(st.cfg_oe))
		else $error("overridden output enable wrong");

	default_oe_a: assert property (!st.cfg_ovr |=>
		output_enable && output_sleep_state_select)
		else $error("default output controls not 1");

	override_sleep_a: assert property (st.cfg_ovr |=>
		output_sleep_state_select == $past(st.cfg_sleep))
		else $error("overridden sleep state wrong");

	clock_swap_a: assert property ((st.cfg_aclk && !link_lock) |=>
		internal_oscillator_on_pclk ##0 $past(!link_lock))
		else $error("oscillator not routed on loss of lock");

	// The swap must also stay off while locked or disabled
	clock_hold_a: assert property ((!st.cfg_aclk || link_lock) |=>
		!internal_oscillator_on_pclk)
		else $error("oscillator routed while locked or disabled");

	rsv_read_a: assert property ((reg_rd && reg_addr == `DGCR_OFS_CFG0) |=>
		reg_rvalid && reg_rdata[3:0] == 4'h0)
		else $error("reserved config bits not zero");

	full_rst_c: cover property (full_if.trig ##[1:10] core_reset_n);
	logic_rst_c: cover property (logic_if.trig && !full_busy ##1 logic_busy);
	override_c: cover property (wr_cfg && reg_wdata[6] && !reg_wdata[7] ##2 !output_enable);
	clock_swap_c: cover property (st.cfg_aclk && !link_lock ##1 internal_oscillator_on_pclk);
endmodule // dgcr_ctrl
`default_nettype wire

// ===== bench/dgcr_host_model.sv
// Purpose: Host controller model on the register strobe port.
// Assumes: One access per call; strobes change just after a clock edge.
// Notes:   Released lines show the inverse of their last value.
`timescale 1ns/10ps
`default_nettype none
module dgcr_host_model
(
	input  wire logic       clk,
	output logic            reg_wr,
	output logic            reg_rd,
	output logic [7:0]      reg_addr,
	output logic [7:0]      reg_wdata,
	input  wire logic [7:0] reg_rdata,
	input  wire logic       reg_rvalid
);
	// Idle port at time zero
	initial
	begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end

	// One-cycle write strobe; lines are scrambled after release
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
	begin
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	end
	endtask

	// Answer must show one cycle after the strobe, else unknown is returned
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
	begin
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1;
		d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
	end
	endtask
endmodule // dgcr_host_model
`default_nettype wire

// ===== bench/tb_top.sv
// Purpose: Self-checking bench for the general control registers.
// Assumes: Pulse length left at its default of 4 cycles.
// Notes:   Strap changes mid-run to tell latched from live values.
`timescale 1ns/10ps
`default_nettype none
`include "dgcr_regs.svh"
module tb_top;
	logic       clk = 1'b0;
	logic       nrst = 1'b0;
	logic [6:0] strap = 7'h2a;
	logic       lock = 1'b1;
	logic       wr, rd, rvalid, oe, sleep_sel, swap, crn;
	logic [7:0] addr, wdata, rdata, d;
	logic [6:0] saddr;
	int         failures = 0;
	int         n_tests = 0;
	int         cyc = 0;

	// 100 MHz clock
	always #5 clk = ~clk;

	dgcr_ctrl #(.SRST_CYCLES(4)) dut
	(
		.clk(clk), .nrst(nrst), .address_strap_pin(strap), .link_lock(lock),
		.reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata),
		.reg_rdata(rdata), .reg_rvalid(rvalid), .slave_addr(saddr),
		.output_enable(oe), .output_sleep_state_select(sleep_sel),
		.internal_oscillator_on_pclk(swap), .core_reset_n(crn)
	);

	dgcr_host_model host
	(
		.clk(clk), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr),
		.reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rvalid)
	);

	task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
	begin
		n_tests++;
		if (seen !== exp)
		begin
			failures++;
			$display("[ERR] %s expected %h seen %h", n, exp, seen);
		end
	end
	endtask

	// Let edges pass, then sample once settled
	task automatic gap(input int n);
	begin
		repeat (n) @(posedge clk);
		#1;
	end
	endtask

	task automatic end_of_test();
	begin
		if (failures == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	end
	endtask

	// Ceiling well above the hundred or fewer cycles the sequence needs
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			failures++;
			end_of_test();
		end
	end

	// Main sequence
	initial
	begin
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		gap(2);
		check("slave_addr", {1'b0, saddr}, 8'h2a);
		check("oe_sleep", {6'h00, oe, sleep_sel}, 8'h03);
		host.rd(`DGCR_OFS_ADDR, d);
		check("addr_reg", d, 8'h54);
		host.rd(`DGCR_OFS_RESET, d);
		check("reset_reg", d, 8'h04);
		host.rd(`DGCR_OFS_CFG0, d);
		check("cfg_reg", d, 8'h80);
		host.rd(8'h07, d);
		check("unmapped", d, 8'h00);
		// An unmapped write must leave the mapped registers alone
		host.wr(8'h07, 8'hff);
		host.rd(`DGCR_OFS_CFG0, d);
		check("cfg_unmapped_wr", d, 8'h80);
		// Register source wins; the new strap must not leak through
		@(posedge clk);
		strap <= 7'h33;
		host.wr(`DGCR_OFS_ADDR, 8'h23);
		gap(2);
		check("slave_addr", {1'b0, saddr}, 8'h11);
		host.wr(`DGCR_OFS_CFG0, 8'hff);
		host.rd(`DGCR_OFS_CFG0, d);
		check("cfg_reg", d, 8'hf0);
		check("swap_locked", {7'h00, swap}, 8'h00);
		@(posedge clk);
		lock <= 1'b0;
		gap(2);
		check("swap_unlocked", {7'h00, swap}, 8'h01);
		host.wr(`DGCR_OFS_CFG0, 8'h40);
		gap(2);
		check("oe_sleep", {6'h00, oe, sleep_sel}, 8'h00);
		check("swap_off", {7'h00, swap}, 8'h00);
		// Override off again: the stored zero enable must not show
		host.wr(`DGCR_OFS_CFG0, 8'h00);
		gap(2);
		check("oe_sleep", {6'h00, oe, sleep_sel}, 8'h03);
		host.wr(`DGCR_OFS_CFG0, 8'h50);
		gap(2);
		check("oe_sleep", {6'h00, oe, sleep_sel}, 8'h01);
		host.wr(`DGCR_OFS_CFG0, 8'hc0);
		gap(2);
		check("oe_sleep", {6'h00, oe, sleep_sel}, 8'h02);
		// Config now holds c0; the logic reset that follows must keep it
		host.wr(`DGCR_OFS_RESET, 8'h01);
		host.rd(`DGCR_OFS_RESET, d);
		check("reset_reg", d, 8'h05);
		check("core_rst", {7'h00, crn}, 8'h00);
		gap(6);
		check("core_rst", {7'h00, crn}, 8'h01);
		host.rd(`DGCR_OFS_CFG0, d);
		check("cfg_kept", d, 8'hc0);
		host.wr(`DGCR_OFS_RESET, 8'h02);
		host.rd(`DGCR_OFS_RESET, d);
		check("reset_reg", d, 8'h06);
		gap(6);
		host.rd(`DGCR_OFS_ADDR, d);
		check("addr_reg", d, 8'h66);
		check("slave_addr", {1'b0, saddr}, 8'h33);
		host.rd(`DGCR_OFS_CFG0, d);
		check("cfg_reg", d, 8'h80);
		host.rd(`DGCR_OFS_RESET, d);
		check("reset_reg", d, 8'h04);
		// Hard reset in mid-run must take up the new strap
		@(posedge clk);
		nrst <= 1'b0;
		strap <= 7'h15;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		gap(2);
		check("slave_addr", {1'b0, saddr}, 8'h15);
		host.rd(`DGCR_OFS_ADDR, d);
		check("addr_reg", d, 8'h2a);
		end_of_test();
	end
endmodule // tb_top
`default_nettype wire
